// ===== rtl/fsw_pkg.sv
// package of constants, types and helpers for the flash status and write-enable unit
package fsw_pkg;

    // ==========================================================
    // status byte layout, msb first
    typedef struct packed {
        logic status_write_disable;
        logic quad_enable;
        logic [3:0] protect_bits;
        logic write_enable_latch;
        logic busy_flag;
    } fsw_status_s;

    localparam int BIT_BUSY = 0;
    localparam int BIT_WEL = 1;
    localparam int BIT_PROTECT_LO = 2;
    localparam int BIT_QE = 6;
    localparam int BIT_STATUS_WRITE_DISABLE = 7;

    // pins as seen from the device, all asynchronous to clk_sys
    typedef struct packed {
        logic sck;
        logic cs_n;
        logic si;
        logic wp_n;
        logic hold_n;
    } fsw_pins_s;

    // ==========================================================
    // reset and shipped values
    localparam logic BUSY_RESET = 1'b0;
    localparam logic WEL_RESET = 1'b0;
    localparam logic [3:0] PROTECT_RESET = 4'h0;
    localparam logic STATUS_WRITE_DISABLE_RESET = 1'b0;

    // ==========================================================
    // opcodes that need a prior write enable
    localparam logic [7:0] OP_PAGE_PROGRAM = 8'h02;
    localparam logic [7:0] OP_QUAD_PAGE_PROGRAM_A = 8'h32;
    localparam logic [7:0] OP_QUAD_PAGE_PROGRAM_B = 8'h38;
    localparam logic [7:0] OP_SECTOR_ERASE_A = 8'hd7;
    localparam logic [7:0] OP_SECTOR_ERASE_B = 8'h20;
    localparam logic [7:0] OP_HALF_BLOCK_ERASE = 8'h52;
    localparam logic [7:0] OP_FULL_BLOCK_ERASE = 8'hd8;
    localparam logic [7:0] OP_CHIP_ERASE_A = 8'hc7;
    localparam logic [7:0] OP_CHIP_ERASE_B = 8'h60;
    localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
    localparam logic [7:0] OP_FUNC_REG_WRITE = 8'h42;
    localparam logic [7:0] OP_INFO_ROW_ERASE = 8'h64;
    localparam logic [7:0] OP_INFO_ROW_PROGRAM = 8'h62;

    // ==========================================================
    // parameter table entries served by this unit
    localparam logic [23:0] TBL_WRAP_OPCODE_ADDR = 24'h000086;
    localparam logic [7:0] TBL_WRAP_OPCODE = 8'hc0;
    localparam logic [23:0] TBL_WRAP_LEN_ADDR = 24'h000087;
    localparam logic [7:0] TBL_WRAP_LEN = 8'h64;
    localparam logic [7:0] TBL_BLANK = 8'hff;

    // ==========================================================
    // frame byte positions
    localparam logic [2:0] IDX_OPCODE = 3'h0;
    localparam logic [2:0] IDX_DATA = 3'h1;
    localparam logic [2:0] IDX_ADDR_LAST = 3'h3;
    localparam logic [2:0] IDX_DUMMY = 3'h4;
    localparam logic [2:0] LEN_ADDR_ONLY = 3'h4;
    localparam logic [2:0] LEN_ADDR_DATA = 3'h5;
    localparam logic [2:0] LEN_OPCODE_DATA = 3'h2;
    localparam logic [2:0] LEN_OPCODE_ONLY = 3'h1;

    // frame length in bytes of a gated opcode, a minimum for programs and register writes, exact for erases; zero when not gated
    function automatic logic [2:0] fsw_gated_len(input logic [7:0] op);
        case (op)
            OP_PAGE_PROGRAM, OP_QUAD_PAGE_PROGRAM_A, OP_QUAD_PAGE_PROGRAM_B,
            OP_INFO_ROW_PROGRAM: fsw_gated_len = LEN_ADDR_DATA;
            OP_SECTOR_ERASE_A, OP_SECTOR_ERASE_B, OP_HALF_BLOCK_ERASE,
            OP_FULL_BLOCK_ERASE, OP_INFO_ROW_ERASE: fsw_gated_len = LEN_ADDR_ONLY;
            OP_CHIP_ERASE_A, OP_CHIP_ERASE_B: fsw_gated_len = LEN_OPCODE_ONLY;
            OP_STATUS_WRITE, OP_FUNC_REG_WRITE: fsw_gated_len = LEN_OPCODE_DATA;
            default: fsw_gated_len = 3'h0;
        endcase
    endfunction : fsw_gated_len

endpackage : fsw_pkg

// ===== rtl/fsw_status_unit.sv
// status register, write-enable gating and register read-out of a serial flash
//
// Functional notes
// [R1] register read repeats same byte until deselect
// [R2] status byte field layout fixed
// [R3] busy reads one during internal cycles
// [R4] busy read-only; writes only when idle
// [R5] write enable command sets latch
// [R6] disable command or completion clears latch
// [R7] status write never touches latch
// [R8] latch low refuses all gated writes
// [R9] host sends write enable before writes
// [R10] program, block erase, status write gated
// [R11] quad program, sector, chip erase gated
// [R12] protection, quad, disable bits via status write
// [R13] shipped protect and disable bits zero
// [R14] status read command returns status byte
// [R15] protect bits mark blocks write-protected
// [R16] quad enable turns on quad output
// [R17] table byte 86h gives wrap opcode
// [R18] table byte 87h gives wrap lengths
// [R19] disable bit with protect pin locks status
// [R20] quad enable repurposes protect and hold pins
// [R21] status stays readable while busy
`timescale 1ns/1ps

module fsw_status_unit #(
    parameter int BUSY_CYCLES = 64,
    parameter logic QE_DEFAULT = 1'b0,
    parameter logic [7:0] OP_WRITE_ENABLE = 8'h06,
    parameter logic [7:0] OP_WRITE_DISABLE = 8'h04,
    parameter logic [7:0] OP_STATUS_READ = 8'h05,
    parameter logic [7:0] OP_TABLE_READ = 8'h5a
) (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire fsw_pkg::fsw_pins_s pins_in,
    output logic so_q,
    output logic so_oe_n_q,
    output fsw_pkg::fsw_status_s status_q,
    output logic quad_mode_q,
    output logic pin_ctl_en_q,
    output logic [3:0] protect_q,
    output logic op_start_q,
    output logic [7:0] op_code_q,
    output logic [23:0] op_addr_q
);
    import fsw_pkg::*;

    localparam int BUSY_W = $clog2(BUSY_CYCLES + 1);

    // ==========================================================
    // pin synchronisers
    logic [4:0] sync1_q;
    logic [4:0] sync2_q;
    logic [4:0] sync3_q;
    fsw_pins_s pin_s;
    fsw_pins_s pin_d;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            // idle pin levels (sck low, cs_n high) so no false edge follows reset
            sync1_q <= 5'h0b;
            sync2_q <= 5'h0b;
            sync3_q <= 5'h0b;
        end else begin
            sync1_q <= pins_in;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
        end
    end

    assign pin_s = sync2_q;
    assign pin_d = sync3_q;

    // ==========================================================
    // state of the status bits
    logic busy_q;
    logic wel_q;
    logic [3:0] bp_q;
    logic qe_q;
    logic status_write_disable_q;
    logic [BUSY_W-1:0] busy_cnt_q;

    // pin roles depend on quad enable
    logic hold_act;
    logic wp_low;
    assign hold_act = !qe_q && !pin_s.hold_n; // [R20]
    assign wp_low = !qe_q && !pin_s.wp_n; // [R20]

    // clock edges are ignored while the part is on hold or deselected
    logic sck_rise;
    logic sck_fall;
    logic frame_end;
    assign sck_rise = pin_s.sck && !pin_d.sck && !pin_s.cs_n && !hold_act;
    assign sck_fall = !pin_s.sck && pin_d.sck && !pin_s.cs_n && !hold_act;
    assign frame_end = pin_s.cs_n && !pin_d.cs_n;

    // ==========================================================
    // frame receive
    logic [2:0] bit_cnt_q;
    logic [2:0] byte_cnt_q;
    logic [6:0] rx_q;
    logic [7:0] opcode_q;
    logic [7:0] data_q;
    logic [23:0] addr_q;
    logic [7:0] byte_now;
    logic byte_done;
    logic [7:0] cur_cmd;

    assign byte_now = {rx_q, pin_s.si};
    assign byte_done = sck_rise && (bit_cnt_q == 3'h7);
    assign cur_cmd = (byte_cnt_q == IDX_OPCODE) ? byte_now : opcode_q;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            bit_cnt_q <= 3'h0;
            byte_cnt_q <= 3'h0;
            rx_q <= 7'h00;
        end else if (pin_s.cs_n) begin
            bit_cnt_q <= 3'h0;
            byte_cnt_q <= 3'h0;
        end else if (sck_rise) begin
            rx_q <= byte_now[6:0];
            bit_cnt_q <= bit_cnt_q + 3'h1;
            // saturate: long data phases only need "at least" lengths
            if (bit_cnt_q == 3'h7 && byte_cnt_q != 3'h7) begin
                byte_cnt_q <= byte_cnt_q + 3'h1;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            opcode_q <= 8'h00;
            data_q <= 8'h00;
            addr_q <= 24'h000000;
        end else if (byte_done) begin
            if (byte_cnt_q == IDX_OPCODE) begin
                opcode_q <= byte_now;
            end
            if (byte_cnt_q == IDX_DATA) begin
                data_q <= byte_now;
            end
            if (byte_cnt_q != IDX_OPCODE && byte_cnt_q <= IDX_ADDR_LAST) begin
                addr_q <= {addr_q[15:0], byte_now};
            end
        end
    end

    // ==========================================================
    // command decode at deselect
    logic whole_bytes;
    logic [2:0] need_len;
    logic is_gated;
    logic len_ok;
    logic status_locked;
    logic erase_all_blocked;
    logic accept;
    logic accept_status;
    logic busy_done;

    assign whole_bytes = frame_end && (bit_cnt_q == 3'h0) && (byte_cnt_q != 3'h0);
    assign need_len = fsw_gated_len(opcode_q); // [R10] [R11]
    assign is_gated = (need_len != 3'h0);
    assign len_ok = (opcode_q == OP_STATUS_WRITE || opcode_q == OP_FUNC_REG_WRITE ||
                     opcode_q == OP_PAGE_PROGRAM || opcode_q == OP_QUAD_PAGE_PROGRAM_A ||
                     opcode_q == OP_QUAD_PAGE_PROGRAM_B || opcode_q == OP_INFO_ROW_PROGRAM) ?
                    (byte_cnt_q >= need_len) : (byte_cnt_q == need_len);
    assign status_locked = status_write_disable_q && wp_low; // [R19]
    // whole-chip erase only runs with no block protected
    assign erase_all_blocked = (opcode_q == OP_CHIP_ERASE_A || opcode_q == OP_CHIP_ERASE_B) &&
                               (bp_q != 4'h0); // [R15]
    // the host is expected to arm the latch first; without it nothing starts
    assign accept = whole_bytes && is_gated && len_ok && wel_q && !busy_q && // [R8] [R4] [R9]
                    !erase_all_blocked &&
                    !(opcode_q == OP_STATUS_WRITE && status_locked); // [R19]
    assign accept_status = accept && (opcode_q == OP_STATUS_WRITE);
    assign busy_done = busy_q && (busy_cnt_q == BUSY_W'(BUSY_CYCLES - 1));

    // ==========================================================
    // busy flag and internal cycle timer
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            busy_q <= BUSY_RESET; // [R3]
            busy_cnt_q <= '0;
        end else if (accept) begin
            busy_q <= 1'b1; // [R3]
            busy_cnt_q <= '0;
        end else if (busy_done) begin
            busy_q <= 1'b0; // [R3]
        end else if (busy_q) begin
            busy_cnt_q <= busy_cnt_q + BUSY_W'(1);
        end
    end

    // ==========================================================
    // write enable latch
    logic set_wel;
    logic clr_wel;
    assign set_wel = whole_bytes && byte_cnt_q == LEN_OPCODE_ONLY &&
                     opcode_q == OP_WRITE_ENABLE;
    assign clr_wel = (whole_bytes && byte_cnt_q == LEN_OPCODE_ONLY &&
                      opcode_q == OP_WRITE_DISABLE) || busy_done;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            wel_q <= WEL_RESET; // [R5]
        end else if (set_wel) begin
            // set wins if completion lands on the same edge
            wel_q <= 1'b1; // [R5] [R7]
        end else if (clr_wel) begin
            wel_q <= 1'b0; // [R6] [R7]
        end
    end

    // ==========================================================
    // non-volatile bits; flops stand in for the cells, so reset reloads
    // the shipped values rather than what was last written
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            bp_q <= PROTECT_RESET; // [R13]
            status_write_disable_q <= STATUS_WRITE_DISABLE_RESET; // [R13]
            qe_q <= QE_DEFAULT; // [R13]
        end else if (accept_status) begin
            bp_q <= data_q[BIT_PROTECT_LO +: 4]; // [R12] [R2]
            qe_q <= data_q[BIT_QE]; // [R12] [R2]
            status_write_disable_q <= data_q[BIT_STATUS_WRITE_DISABLE]; // [R12] [R2]
        end
    end

    // ==========================================================
    // array operation hand-off
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            op_start_q <= 1'b0;
            op_code_q <= 8'h00;
            op_addr_q <= 24'h000000;
        end else begin
            op_start_q <= accept && !accept_status;
            if (accept && !accept_status) begin
                op_code_q <= opcode_q;
                op_addr_q <= addr_q;
            end
        end
    end

    // ==========================================================
    // read-out path
    fsw_status_s live_status;
    logic [7:0] tx_q;
    logic [23:0] rd_ptr_q;
    logic reading_q;
    logic drive_q;
    logic [7:0] tbl_byte;

    always_comb begin
        live_status = '0;
        live_status.status_write_disable = status_write_disable_q;
        live_status.quad_enable = qe_q;
        live_status.protect_bits = bp_q;
        live_status.write_enable_latch = wel_q;
        live_status.busy_flag = busy_q;
    end

    always_comb begin
        tbl_byte = TBL_BLANK;
        if (rd_ptr_q == TBL_WRAP_OPCODE_ADDR) begin
            tbl_byte = TBL_WRAP_OPCODE; // [R17]
        end else if (rd_ptr_q == TBL_WRAP_LEN_ADDR) begin
            tbl_byte = TBL_WRAP_LEN; // [R18]
        end
    end

    // each byte boundary reloads; status is resampled every byte so a
    // polling host sees busy fall without reselecting
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            tx_q <= 8'h00;
            rd_ptr_q <= 24'h000000;
            reading_q <= 1'b0;
        end else if (pin_s.cs_n) begin
            reading_q <= 1'b0;
        end else if (byte_done) begin
            if (cur_cmd == OP_STATUS_READ) begin
                tx_q <= live_status; // [R14] [R1] [R21]
                reading_q <= 1'b1;
            end else if (cur_cmd == OP_TABLE_READ) begin
                if (byte_cnt_q == IDX_ADDR_LAST) begin
                    rd_ptr_q <= {addr_q[15:0], byte_now};
                end else if (byte_cnt_q >= IDX_DUMMY) begin
                    tx_q <= tbl_byte;
                    rd_ptr_q <= rd_ptr_q + 24'h000001;
                    reading_q <= 1'b1;
                end
            end
        end else if (sck_fall && reading_q) begin
            tx_q <= {tx_q[6:0], 1'b0};
        end
    end

    // data changes on the falling clock edge for the host's next rising edge
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            so_q <= 1'b0;
            drive_q <= 1'b0;
        end else if (pin_s.cs_n) begin
            drive_q <= 1'b0;
        end else if (sck_fall && reading_q) begin
            so_q <= tx_q[7];
            drive_q <= 1'b1;
        end
    end

    // output released on hold and on deselect
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            so_oe_n_q <= 1'b1;
        end else begin
            so_oe_n_q <= !(drive_q && !pin_s.cs_n && !hold_act);
        end
    end

    // ==========================================================
    // registered view of the status and pin roles
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            status_q <= '0;
            quad_mode_q <= 1'b0;
            pin_ctl_en_q <= 1'b1;
            protect_q <= PROTECT_RESET;
        end else begin
            status_q <= live_status; // [R2]
            quad_mode_q <= qe_q; // [R16]
            pin_ctl_en_q <= !qe_q; // [R20]
            protect_q <= bp_q; // [R15]
        end
    end

endmodule : fsw_status_unit

// ===== tb/fsw_monitor.sv
// port checker for the flash status unit
`timescale 1ns/1ps
module fsw_monitor
    import fsw_pkg::*;
#(
    parameter int BUSY_CYCLES = 64
) (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire fsw_pkg::fsw_pins_s pins_in,
    input wire logic so_q,
    input wire logic so_oe_n_q,
    input wire fsw_pkg::fsw_status_s status_q,
    input wire logic quad_mode_q,
    input wire logic pin_ctl_en_q,
    input wire logic [3:0] protect_q,
    input wire logic op_start_q,
    input wire logic [7:0] op_code_q,
    input wire logic [23:0] op_addr_q
);
    int busy_run_q;
    default clocking mon_cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    // ==========================================================
    // busy span counter, too long for a repetition
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            busy_run_q <= 0;
        end else begin
            busy_run_q <= status_q.busy_flag ? busy_run_q + 1 : 0;
        end
    end
    // ==========================================================
    // assertions
    a_busy_span_len: assert property ($fell(status_q.busy_flag) |->
        busy_run_q >= BUSY_CYCLES - 1 && busy_run_q <= BUSY_CYCLES + 1)
        else $error("busy span length wrong");
    a_busy_run_bound: assert property (busy_run_q <= BUSY_CYCLES + 1)
        else $error("busy held too long");
    a_start_needs_wel: assert property (op_start_q |->
        $past(status_q.write_enable_latch) && !$past(status_q.busy_flag))
        else $error("op started without latch or while busy");
    a_busy_needs_wel: assert property ($rose(status_q.busy_flag) |->
        $past(status_q.write_enable_latch))
        else $error("busy began without latch");
    a_start_then_busy: assert property (op_start_q |-> ##[0:2] status_q.busy_flag)
        else $error("op start without busy");
    a_wel_clears_done: assert property ($fell(status_q.busy_flag) |->
        ##[0:1] !status_q.write_enable_latch)
        else $error("latch not cleared at completion");
    a_wel_set_frame: assert property ($rose(status_q.write_enable_latch) |-> pins_in.cs_n)
        else $error("latch set inside a frame");
    a_pin_mode_split: assert property (quad_mode_q != pin_ctl_en_q)
        else $error("pin mode outputs agree");
    a_protect_track: assert property ((protect_q != status_q.protect_bits) |->
        ##1 (protect_q == status_q.protect_bits))
        else $error("protect outputs differ from status");
    a_protect_write_only: assert property (!$stable(protect_q) |-> status_q.busy_flag)
        else $error("protect bits changed outside a status write");
    a_out_idle_off: assert property (pins_in.cs_n [*6] |-> so_oe_n_q)
        else $error("output driven while deselected");
    c_op_start: cover property (op_start_q);
    c_busy_rise: cover property ($rose(status_q.busy_flag));
    c_out_drive: cover property (!so_oe_n_q);
endmodule : fsw_monitor

bind fsw_status_unit fsw_monitor #(.BUSY_CYCLES(BUSY_CYCLES)) fsw_monitor_inst (
    .clk_sys(clk_sys), .arst_n(arst_n), .pins_in(pins_in), .so_q(so_q),
    .so_oe_n_q(so_oe_n_q), .status_q(status_q), .quad_mode_q(quad_mode_q),
    .pin_ctl_en_q(pin_ctl_en_q), .protect_q(protect_q), .op_start_q(op_start_q),
    .op_code_q(op_code_q), .op_addr_q(op_addr_q));

// ===== tb/fsw_host.sv
// host serial controller model, mode 0, 400 ns serial clock
`timescale 1ns/1ps
module fsw_host (
    output fsw_pkg::fsw_pins_s pins,
    input wire logic so,
    input wire logic so_oe_n
);
    import fsw_pkg::*;
    logic [7:0] rx_byte;
    event rx_ev;
    initial begin
        pins = '{sck: 1'b0, cs_n: 1'b1, si: 1'b0, wp_n: 1'b1, hold_n: 1'b1};
    end
    task automatic set_wp(input logic v);
        pins.wp_n = v;
    endtask : set_wp
    // ==========================================================
    // one framed command; sck idles low between frames
    task automatic frame(input logic [7:0] tx[$], input int nrx);
        logic [7:0] b;
        pins.cs_n = 1'b0;
        for (int i = 0; i < tx.size() + nrx; i++) begin
            b = (i < tx.size()) ? tx[i] : 8'h00;
            for (int k = 7; k >= 0; k--) begin
                pins.si = b[k];
                #250;
                pins.sck = 1'b1;
                // a released output reads inverted, so a missing enable shows up
                rx_byte[k] = so_oe_n ? ~so : so;
                #150;
                pins.sck = 1'b0;
            end
            if (i >= tx.size()) -> rx_ev;
        end
        #100;
        pins.cs_n = 1'b1;
        // released data line must not keep the last bit
        pins.si = ~pins.si;
        #1000;
    endtask : frame
endmodule : fsw_host

// ===== tb/fsw_status_unit_bench.sv
// self-checking bench for the flash status unit
`timescale 1ns/1ps
module fsw_status_unit_bench;
    import fsw_pkg::*;
    localparam int BUSY = 300;
    localparam logic [7:0] CMD_WEN = 8'h06;
    localparam logic [7:0] CMD_WDIS = 8'h04;
    localparam logic [7:0] CMD_SRD = 8'h05;
    logic clk_sys, arst_n, so_q, so_oe_n_q, quad_mode_q, pin_ctl_en_q, op_start_q;
    fsw_pins_s pins_in;
    fsw_status_s status_q;
    logic [3:0] protect_q;
    logic [7:0] op_code_q;
    logic [23:0] op_addr_q;
    logic [7:0] exp_q[$];
    logic [32:0] op_q[$];
    int miscompares = 0;
    int compares = 0;
    logic [7:0] ops [12] = '{8'h02, 8'h32, 8'h38, 8'h62, 8'hd7, 8'h20, 8'h52, 8'hd8,
        8'h64, 8'hc7, 8'h60, 8'h42};
    int lens [12] = '{5, 5, 5, 5, 4, 4, 4, 4, 4, 1, 1, 2};

    fsw_status_unit #(.BUSY_CYCLES(BUSY)) fsw_status_unit_inst (
        .clk_sys(clk_sys), .arst_n(arst_n), .pins_in(pins_in), .so_q(so_q),
        .so_oe_n_q(so_oe_n_q), .status_q(status_q), .quad_mode_q(quad_mode_q),
        .pin_ctl_en_q(pin_ctl_en_q), .protect_q(protect_q), .op_start_q(op_start_q),
        .op_code_q(op_code_q), .op_addr_q(op_addr_q));
    fsw_host fsw_host_inst (.pins(pins_in), .so(so_q), .so_oe_n(so_oe_n_q));

    // ==========================================================
    // checking and reporting
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        compares++;
        if (seen !== want) begin
            miscompares++;
            $display("[ERR] t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask : check
    task automatic summarize();
        $display("compares=%0d miscompares=%0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : summarize
    task automatic rd(input int n, input logic [7:0] want);
        repeat (n) exp_q.push_back(want);
        fsw_host_inst.frame({CMD_SRD}, n);
    endtask : rd
    task automatic wait_idle();
        int n;
        n = 0;
        while (status_q.busy_flag !== 1'b0 && n < 2000) begin
            @(posedge clk_sys);
            n++;
        end
        check(n < 2000, 1);
        @(posedge clk_sys);
        #1;
    endtask : wait_idle

    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    initial begin
        #3_000_000;
        miscompares++;
        summarize();
    end
    // ==========================================================
    // result watchers: every byte read and every started op takes a note
    initial begin
        forever begin
            @(fsw_host_inst.rx_ev);
            if (exp_q.size() == 0) check(fsw_host_inst.rx_byte, 32'hffff_ffff);
            else check(fsw_host_inst.rx_byte, exp_q.pop_front());
        end
    end
    always @(posedge clk_sys) begin
        if (op_start_q !== 1'b0) begin
            if (op_q.size() == 0) begin
                check(op_start_q, 0);
            end else begin
                check(op_code_q, op_q[0][31:24]);
                if (op_q[0][32]) check(op_addr_q, op_q[0][23:0]);
                void'(op_q.pop_front());
            end
        end
    end

    initial begin
        logic [31:0] a;
        logic [7:0] d;
        arst_n = 1'b0;
        void'($urandom(64120));
        repeat (4) @(posedge clk_sys);
        #1 arst_n = 1'b1;
        repeat (6) @(posedge clk_sys);
        #1;
        rd(3, 8'h00);
        fsw_host_inst.frame({CMD_WEN}, 0);
        rd(1, 8'h02);
        fsw_host_inst.frame({CMD_WDIS}, 0);
        rd(1, 8'h00);
        fsw_host_inst.frame({8'h02, 8'h01, 8'h02, 8'h03, 8'h55}, 0);
        rd(1, 8'h00);
        $display("test basics done");
        fsw_host_inst.frame({8'h5a, 8'h00, 8'h00, 8'h86, 8'h00}, 0);
        exp_q.push_back(8'hc0);
        exp_q.push_back(8'h64);
        exp_q.push_back(8'hff);
        fsw_host_inst.frame({8'h5a, 8'h00, 8'h00, 8'h86, 8'h00}, 3);
        $display("test table done");
        for (int i = 0; i < 12; i++) begin
            a = $urandom;
            fsw_host_inst.frame({CMD_WEN}, 0);
            op_q.push_back({lens[i] >= 4, ops[i], a[23:0]});
            if (lens[i] == 1) fsw_host_inst.frame({ops[i]}, 0);
            else if (lens[i] == 2) fsw_host_inst.frame({ops[i], a[7:0]}, 0);
            else if (lens[i] == 4) fsw_host_inst.frame({ops[i], a[23:16], a[15:8], a[7:0]}, 0);
            else fsw_host_inst.frame({ops[i], a[23:16], a[15:8], a[7:0], a[31:24]}, 0);
            rd(1, 8'h03);
            wait_idle();
            rd(1, 8'h00);
        end
        $display("test gated ops done");
        d = {1'b0, 7'($urandom)} & 8'h7c;
        fsw_host_inst.frame({CMD_WEN}, 0);
        fsw_host_inst.frame({8'h01, d}, 0);
        rd(1, d | 8'h03);
        wait_idle();
        rd(1, d);
        check(protect_q, d[5:2]);
        check(quad_mode_q, d[6]);
        check(pin_ctl_en_q, !d[6]);
        check(status_q, d);
        fsw_host_inst.frame({CMD_WEN}, 0);
        fsw_host_inst.frame({8'h01, 8'h84}, 0);
        wait_idle();
        fsw_host_inst.frame({CMD_WEN}, 0);
        fsw_host_inst.frame({8'hc7}, 0);
        rd(1, 8'h86);
        fsw_host_inst.set_wp(1'b0);
        fsw_host_inst.frame({8'h01, 8'h00}, 0);
        rd(1, 8'h86);
        fsw_host_inst.set_wp(1'b1);
        fsw_host_inst.frame({8'h01, 8'h00}, 0);
        rd(1, 8'h03);
        wait_idle();
        rd(1, 8'h00);
        $display("test status write done");
        fsw_host_inst.frame({CMD_WEN}, 0);
        arst_n = 1'b0;
        repeat (2) @(posedge clk_sys);
        #1 arst_n = 1'b1;
        repeat (6) @(posedge clk_sys);
        #1;
        check(status_q, 8'h00);
        rd(1, 8'h00);
        $display("test reset done");
        op_q.push_back({1'b0, 8'hc7, 24'h0});
        fsw_host_inst.frame({CMD_WEN}, 0);
        fsw_host_inst.frame({8'hc7}, 0);
        fsw_host_inst.frame({CMD_WEN}, 0);
        fsw_host_inst.frame({8'hc7}, 0);
        wait_idle();
        rd(1, 8'h00);
        $display("test busy refusal done");
        check(exp_q.size() + op_q.size(), 0);
        summarize();
    end
endmodule : fsw_status_unit_bench
